// ### core/io_xfer_pkg.sv
// Constants shared by the I/O transfer host controller and its decoder.
package io_xfer_pkg;

    // ------------------------------------------------------------------
    // Word layout
    // ------------------------------------------------------------------
    // Instruction bits are numbered from the most significant end (bit 0 is
    // the MSB). The numbers below are kept as printed and mapped to indices.
    localparam int WORD_W       = 16;
    localparam int UNIT_W       = 6;
    localparam int ADDR_W       = 15;
    localparam int ADDR_LOW_W   = 14;
    localparam int CHAR_W       = 8;

    localparam int NUM_MERGE    = 4;
    localparam int NUM_INDIRECT = 5;
    localparam int NUM_MAP      = 6;
    localparam int NUM_WAIT     = 9;
    localparam int NUM_UNIT_LO  = 10;
    localparam int NUM_UNIT_HI  = 15;
    localparam int NUM_AW_IND   = 0;
    localparam int NUM_AW_INDEX = 1;

    localparam int IDX_MERGE    = WORD_W - 1 - NUM_MERGE;
    localparam int IDX_INDIRECT = WORD_W - 1 - NUM_INDIRECT;
    localparam int IDX_MAP      = WORD_W - 1 - NUM_MAP;
    localparam int IDX_WAIT     = WORD_W - 1 - NUM_WAIT;
    localparam int IDX_UNIT_HI  = WORD_W - 1 - NUM_UNIT_LO;
    localparam int IDX_UNIT_LO  = WORD_W - 1 - NUM_UNIT_HI;
    localparam int IDX_AW_IND   = WORD_W - 1 - NUM_AW_IND;
    localparam int IDX_AW_INDEX = WORD_W - 1 - NUM_AW_INDEX;

    // ------------------------------------------------------------------
    // Reset values and synchroniser depth
    // ------------------------------------------------------------------
    localparam logic [WORD_W-1:0] RST_WORD = 16'h0000;
    localparam logic [ADDR_W-1:0] RST_ADDR = 15'h0000;
    localparam logic [UNIT_W-1:0] RST_UNIT = 6'h00;
    localparam int                SYNC_N   = 3;
    localparam int                PIN_N    = 3 + WORD_W;

endpackage : io_xfer_pkg

// ### core/xfer_dec_if.sv
// Interface between the transfer controller and its instruction decoder.
`timescale 1ns/1ps
`default_nettype none
interface xfer_dec_if;
    import io_xfer_pkg::*;
    logic [WORD_W-1:0] instr;
    logic [WORD_W-1:0] operand;
    logic [WORD_W-1:0] acc;
    logic [WORD_W-1:0] in_data;
    logic [ADDR_W-1:0] pc;
    logic              is_mem;
    logic              ready;
    logic              wait_mode;
    logic [UNIT_W-1:0] unit;
    logic              merge;
    logic              indirect;
    logic [ADDR_W-1:0] eff_addr;
    logic              chain;
    logic              index;
    logic [WORD_W-1:0] acc_next;
    logic [ADDR_W-1:0] pc_next;

    modport dec (input instr, operand, acc, in_data, pc, is_mem, ready,
                 output wait_mode, unit, merge, indirect, eff_addr, chain, index,
                 acc_next, pc_next);
    modport ctl (output instr, operand, acc, in_data, pc, is_mem, ready,
                 input wait_mode, unit, merge, indirect, eff_addr, chain, index,
                 acc_next, pc_next);
endinterface : xfer_dec_if
`default_nettype wire

// ### core/xfer_decode.sv
// Flag decoding, merge load, direct address and program register advance.
`timescale 1ns/1ps
`default_nettype none
module xfer_decode
    import io_xfer_pkg::*;
(
    xfer_dec_if.dec d
);

    // ------------------------------------------------------------------
    // Instruction flags
    // ------------------------------------------------------------------
    // Wait flag and unit number sit in the low end of the word.
    assign d.wait_mode = d.instr[IDX_WAIT];                 // R14
    assign d.unit      = d.instr[IDX_UNIT_HI:IDX_UNIT_LO];  // R14
    assign d.merge     = d.instr[IDX_MERGE];
    assign d.indirect  = d.instr[IDX_INDIRECT];             // R19

    // ------------------------------------------------------------------
    // Direct address
    // ------------------------------------------------------------------
    // Immediate mode takes the second word as the address itself; address
    // mode takes 14 bits and, if the page bit is set, the top bit of the program register.
    always_comb begin
        if (!d.indirect) begin
            d.eff_addr = d.operand[ADDR_W-1:0];                                     // R19
        end else begin
            d.eff_addr = {d.instr[IDX_MAP] & d.pc[ADDR_W-1],
                          d.operand[ADDR_LOW_W-1:0]};                               // R20
        end
    end

    // Chain and index requests are passed up; the caller resolves them.
    assign d.chain = d.is_mem & d.indirect & d.operand[IDX_AW_IND];     // R21
    assign d.index = d.is_mem & d.indirect & d.operand[IDX_AW_INDEX];   // R21

    // ------------------------------------------------------------------
    // Accumulator load
    // ------------------------------------------------------------------
    // A merge ORs the character into the low half and keeps the high half.
    always_comb begin
        if (d.merge) begin
            d.acc_next = {d.acc[WORD_W-1:CHAR_W],
                          d.acc[CHAR_W-1:0] | d.in_data[CHAR_W-1:0]};   // R17 R18
        end else begin
            d.acc_next = d.in_data;                                     // R17
        end
    end

    // ------------------------------------------------------------------
    // Program register advance
    // ------------------------------------------------------------------
    // One step per instruction word, plus one more to skip when ready.
    assign d.pc_next = ADDR_W'(d.pc + ADDR_W'(d.is_mem) + 15'h0001
                              + ADDR_W'(d.ready));                      // R15 R22

endmodule : xfer_decode
`default_nettype wire

// ### core/io_xfer_host.sv
// Mainframe side of the peripheral word transfer handshake.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// R1: Device raises ready test return only when selected and buffer ready.
// R2: Wait mode with buffer not ready: host stays in sync, device keeps testing.
// R3: Skip mode not ready: device returns sync return with test return low.
// R4: Dropping instruction sync clears both device returns.
// R5: Data valid to ready unit loads device register and raises word taken.
// R6: Host holds data valid until word taken acknowledge arrives.
// R7: Dropping data valid clears the device word taken flip-flop.
// R8: Host holds transfer instruction active for the whole transfer instruction.
// R9: Word taken sets only with instruction, select, data valid and not set.
// R10: Sync with select releases device test flip-flop and gates its clocks.
// R11: Device test return sets only when buffer ready, setting sync return too.
// R12: Wait mode: device sync return follows test return only.
// R13: Skip mode: device sync return sets on first gated clock.
// R14: Wait flag is bit 9, unit number bits 10 to 15.
// R15: Skip mode advances program register twice if ready, once if not.
// R16: While waiting, block all interrupts except power-fail and stall alarm.
// R17: Merge clear loads whole word; merge set loads low character only.
// R18: Merge ORs the character with existing low accumulator half.
// R19: Memory input: indirect flag clear is immediate, set is address mode.
// R20: Direct address: 14 low bits, top bit from program register if page set.
// R21: Honour indirect chaining and index flags of the address word.
// R22: Accumulator form is one word, memory form two; three cycles least.
// R23: Instruction sync rises after the instruction level, gated by unit.
// R24: Data valid is driven with the word on the bus after test return.
// R25: Bus levels are active high inside, all logic on one clock.
module io_xfer_host
    import io_xfer_pkg::*;
(
    input  wire logic              i_clk_sys,
    input  wire logic              i_resetn,
    // User command port.
    input  wire logic              i_cmd_valid,
    output logic                   o_cmd_ready,
    input  wire logic              i_cmd_input,
    input  wire logic              i_cmd_mem,
    input  wire logic [WORD_W-1:0] i_cmd_instr,
    input  wire logic [WORD_W-1:0] i_cmd_operand,
    input  wire logic [WORD_W-1:0] i_cmd_acc,
    input  wire logic [ADDR_W-1:0] i_cmd_pc,
    output logic                   o_done,
    output logic                   o_dev_ready,
    output logic [ADDR_W-1:0]      o_pc_next,
    output logic [WORD_W-1:0]      o_acc_next,
    output logic [ADDR_W-1:0]      o_mem_addr,
    output logic                   o_mem_write,
    output logic                   o_chain,
    output logic                   o_index,
    output logic                   o_irq_block,
    // I/O bus toward the peripheral, active high.
    output logic                   o_xfer_instr,
    output logic                   o_instr_sync,
    output logic                   o_wait_mode,
    output logic [UNIT_W-1:0]      o_unit,
    output logic                   o_data_here,
    output logic [WORD_W-1:0]      o_bus_data,
    input  wire logic              i_ready_test_return,
    input  wire logic              i_cycle_sync_return,
    input  wire logic              i_word_taken_ack,
    input  wire logic [WORD_W-1:0] i_bus_data
);

    typedef enum logic [2:0] {ST_IDLE, ST_ARM, ST_SYNC, ST_TEST, ST_DATA,
                              ST_RELEASE} state_t;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // Each pin passes three flops; a level only moves once stages two and
    // three agree, so a bus word caught mid-change is never taken.
    logic [PIN_N-1:0] pin_s1;
    logic [PIN_N-1:0] pin_s2;
    logic [PIN_N-1:0] pin_s3;
    logic [PIN_N-1:0] pin_lvl;
    logic [PIN_N-1:0] next_pin_lvl;

    always_comb begin
        for (int i = 0; i < PIN_N; i++) begin
            next_pin_lvl[i] = (pin_s2[i] == pin_s3[i]) ? pin_s3[i] : pin_lvl[i];
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            pin_s1  <= '0;
            pin_s2  <= '0;
            pin_s3  <= '0;
            pin_lvl <= '0;
        end else begin
            pin_s1  <= {i_ready_test_return, i_cycle_sync_return, i_word_taken_ack, // R25
                        i_bus_data};
            pin_s2  <= pin_s1;
            pin_s3  <= pin_s2;
            pin_lvl <= next_pin_lvl;
        end
    end

    logic rtr_lvl;
    logic csr_lvl;
    logic wta_lvl;
    assign rtr_lvl = pin_lvl[PIN_N-1];
    assign csr_lvl = pin_lvl[PIN_N-2];
    assign wta_lvl = pin_lvl[PIN_N-3];

    // ------------------------------------------------------------------
    // Command latch and decoder
    // ------------------------------------------------------------------
    state_t            state;
    state_t            next_state;
    logic              is_input;
    logic              next_is_input;
    logic              is_mem;
    logic              next_is_mem;
    logic [WORD_W-1:0] instr;
    logic [WORD_W-1:0] next_instr;
    logic [WORD_W-1:0] operand;
    logic [WORD_W-1:0] next_operand;
    logic [WORD_W-1:0] acc;
    logic [WORD_W-1:0] next_acc;
    logic [ADDR_W-1:0] pc;
    logic [ADDR_W-1:0] next_pc;
    logic [WORD_W-1:0] in_word;
    logic [WORD_W-1:0] next_in_word;
    logic              ready;
    logic              next_ready;

    xfer_dec_if dec_bus ();
    assign dec_bus.instr   = instr;
    assign dec_bus.operand = operand;
    assign dec_bus.acc     = acc;
    assign dec_bus.in_data = in_word;
    assign dec_bus.pc      = pc;
    assign dec_bus.is_mem  = is_mem;
    assign dec_bus.ready   = ready;

    xfer_decode xfer_decode_inst (
        .d (dec_bus.dec)
    );

    // ------------------------------------------------------------------
    // Transfer sequencer
    // ------------------------------------------------------------------
    logic              next_xfer_instr;
    logic              next_instr_sync;
    logic              next_data_here;
    logic [WORD_W-1:0] next_bus_data;
    logic              next_done;
    logic              next_dev_ready;
    logic [ADDR_W-1:0] next_pc_next;
    logic [WORD_W-1:0] next_acc_next;
    logic [ADDR_W-1:0] next_mem_addr;
    logic              next_mem_write;
    logic              next_chain;
    logic              next_index;

    always_comb begin
        next_state      = state;
        next_is_input   = is_input;
        next_is_mem     = is_mem;
        next_instr      = instr;
        next_operand    = operand;
        next_acc        = acc;
        next_pc         = pc;
        next_in_word    = in_word;
        next_ready      = ready;
        next_xfer_instr = o_xfer_instr;
        next_instr_sync = o_instr_sync;
        next_data_here  = o_data_here;
        next_bus_data   = o_bus_data;
        next_done       = 1'b0;
        next_dev_ready  = o_dev_ready;
        next_pc_next    = o_pc_next;
        next_acc_next   = o_acc_next;
        next_mem_addr   = o_mem_addr;
        next_mem_write  = 1'b0;
        next_chain      = o_chain;
        next_index      = o_index;
        unique case (state)
            ST_IDLE: begin
                if (i_cmd_valid) begin
                    next_is_input   = i_cmd_input;
                    next_is_mem     = i_cmd_mem;
                    next_instr      = i_cmd_instr;
                    next_operand    = i_cmd_operand;
                    next_acc        = i_cmd_acc;
                    next_pc         = i_cmd_pc;
                    next_ready      = 1'b0;
                    next_xfer_instr = 1'b1;                                 // R8
                    next_state      = ST_ARM;
                end
            end
            ST_ARM: begin
                // The instruction level settles a cycle before sync rises.
                next_instr_sync = 1'b1;                                     // R23
                next_state      = ST_SYNC;
            end
            ST_SYNC: begin
                // In wait mode the unit withholds its return; stay here.
                if (csr_lvl) begin                                          // R2
                    next_state = ST_TEST;
                end
            end
            ST_TEST: begin
                // One cycle of slack lets the test return land beside sync.
                next_ready   = rtr_lvl;                                     // R15
                next_in_word = pin_lvl[WORD_W-1:0];
                if (rtr_lvl && !is_input) begin
                    next_bus_data  = is_mem ? operand : acc;                // R22
                    next_data_here = 1'b1;                                  // R24
                    next_state     = ST_DATA;
                end else begin
                    next_instr_sync = 1'b0;
                    next_state      = ST_RELEASE;
                end
            end
            ST_DATA: begin
                // Data valid stays up until the unit says it took the word.
                if (wta_lvl) begin                                          // R6
                    next_data_here  = 1'b0;                                 // R7
                    next_instr_sync = 1'b0;                                 // R4
                    next_state      = ST_RELEASE;
                end
            end
            ST_RELEASE: begin
                if (!csr_lvl && !wta_lvl) begin
                    next_xfer_instr = 1'b0;                                 // R8
                    next_done       = 1'b1;
                    next_dev_ready  = ready;
                    next_pc_next    = dec_bus.pc_next;                      // R15
                    next_acc_next   = (is_input && !is_mem && ready) ?
                                      dec_bus.acc_next : acc;               // R17
                    next_mem_addr   = dec_bus.eff_addr;                     // R19 R20
                    next_mem_write  = is_input & is_mem & ready;
                    next_chain      = dec_bus.chain;                        // R21
                    next_index      = dec_bus.index;
                    next_state      = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            state        <= ST_IDLE;
            is_input     <= 1'b0;
            is_mem       <= 1'b0;
            instr        <= RST_WORD;
            operand      <= RST_WORD;
            acc          <= RST_WORD;
            pc           <= RST_ADDR;
            in_word      <= RST_WORD;
            ready        <= 1'b0;
            o_xfer_instr <= 1'b0;
            o_instr_sync <= 1'b0;
            o_data_here  <= 1'b0;
            o_bus_data   <= RST_WORD;
            o_done       <= 1'b0;
            o_dev_ready  <= 1'b0;
            o_pc_next    <= RST_ADDR;
            o_acc_next   <= RST_WORD;
            o_mem_addr   <= RST_ADDR;
            o_mem_write  <= 1'b0;
            o_chain      <= 1'b0;
            o_index      <= 1'b0;
        end else begin
            state        <= next_state;
            is_input     <= next_is_input;
            is_mem       <= next_is_mem;
            instr        <= next_instr;
            operand      <= next_operand;
            acc          <= next_acc;
            pc           <= next_pc;
            in_word      <= next_in_word;
            ready        <= next_ready;
            o_xfer_instr <= next_xfer_instr;
            o_instr_sync <= next_instr_sync;
            o_data_here  <= next_data_here;
            o_bus_data   <= next_bus_data;
            o_done       <= next_done;
            o_dev_ready  <= next_dev_ready;
            o_pc_next    <= next_pc_next;
            o_acc_next   <= next_acc_next;
            o_mem_addr   <= next_mem_addr;
            o_mem_write  <= next_mem_write;
            o_chain      <= next_chain;
            o_index      <= next_index;
        end
    end

    // Unit number and wait flag come unregistered from the held instruction, forced to zero while the transfer instruction is low.
    assign o_unit      = o_xfer_instr ? dec_bus.unit : RST_UNIT;            // R14
    assign o_wait_mode = o_xfer_instr & dec_bus.wait_mode;
    assign o_cmd_ready = (state == ST_IDLE);
    // Only power-fail and stall alarm may break in while waiting.
    assign o_irq_block = o_instr_sync & dec_bus.wait_mode & ~csr_lvl;      // R16

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    AST_SYNC_IN_INSTR: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // R8
        o_instr_sync |-> o_xfer_instr)
        else $error("instruction sync without transfer instruction");
    AST_SYNC_AFTER_ARM: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // R23
        $rose(o_xfer_instr) |-> !o_instr_sync ##1 o_instr_sync)
        else $error("instruction sync did not follow instruction level");
    AST_WAIT_HOLDS: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // R2
        (state == ST_SYNC && !csr_lvl) |=> (state == ST_SYNC) && o_instr_sync)
        else $error("left sync state without sync return");
    AST_DATA_AFTER_TEST: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // R24
        $rose(o_data_here) |-> ready && $past(rtr_lvl) && o_bus_data == (is_mem ? operand : acc))
        else $error("data valid raised without test return");
    AST_DATA_HELD: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // R6
        (o_data_here && !wta_lvl) |=> o_data_here)
        else $error("data valid dropped before acknowledge");
    AST_PC_ADVANCE: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // R15
        o_done |-> o_pc_next == ADDR_W'(pc + ADDR_W'(is_mem) + 15'h0001 + ADDR_W'(o_dev_ready)))
        else $error("program register advance wrong");
    AST_MERGE_KEEPS: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // R18
        (o_done && is_input && !is_mem && o_dev_ready && instr[IDX_MERGE]) |->
        o_acc_next == {acc[WORD_W-1:CHAR_W], acc[CHAR_W-1:0] | in_word[CHAR_W-1:0]})
        else $error("merge load wrong");
    AST_PAGE_BIT: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // R20
        (o_done && instr[IDX_INDIRECT] && !instr[IDX_MAP]) |-> !o_mem_addr[ADDR_W-1])
        else $error("page bit clear but top address bit set");
    AST_IRQ_WAIT: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // R16
        o_irq_block |-> o_instr_sync && o_wait_mode && state == ST_SYNC)
        else $error("interrupt block outside a wait");

endmodule : io_xfer_host
`default_nettype wire

// ### dv/io_periph_model.sv
// Behavioural peripheral answering the host's word transfer handshake.
`timescale 1ns/1ps
`default_nettype none
module io_periph_model
    import io_xfer_pkg::*;
#(
    parameter logic [UNIT_W-1:0] MY_UNIT = 6'h2A
)
(
    input  wire logic              i_clk_sys,
    input  wire logic              i_resetn,
    input  wire logic              i_xfer_instr,
    input  wire logic              i_instr_sync,
    input  wire logic              i_wait_mode,
    input  wire logic [UNIT_W-1:0] i_unit,
    input  wire logic              i_data_here,
    input  wire logic [WORD_W-1:0] i_bus_data,
    input  wire logic              i_buf_ready,
    input  wire logic [WORD_W-1:0] i_in_word,
    output logic                   o_ready_test_return,
    output logic                   o_cycle_sync_return,
    output logic                   o_word_taken_ack,
    output logic [WORD_W-1:0]      o_out_reg,
    output logic [WORD_W-1:0]      o_bus_data
);
    logic this_unit;
    logic sel;
    logic ack_ff;

    // Unit select gates the return flip-flops and the word load; without it the test flip-flop is held cleared.
    assign this_unit = i_xfer_instr && (i_unit == MY_UNIT);
    assign sel       = this_unit && i_instr_sync;

    // Return flip-flops and the acknowledge latch, all on the mainframe clock.
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_ready_test_return <= 1'b0;
            o_cycle_sync_return <= 1'b0;
            ack_ff              <= 1'b0;
            o_out_reg           <= 16'h0000;
        end else begin
            if (!sel) begin
                o_ready_test_return <= 1'b0;
                o_cycle_sync_return <= 1'b0;
            end else if (i_buf_ready) begin
                o_ready_test_return <= 1'b1;
                o_cycle_sync_return <= 1'b1;
            end else if (!i_wait_mode) begin
                o_cycle_sync_return <= 1'b1;
            end
            // In wait mode nothing sets while the buffer is busy, so the host stalls.
            if (!i_data_here) begin
                ack_ff <= 1'b0;
            end else if (this_unit && !ack_ff) begin
                ack_ff    <= 1'b1;
                o_out_reg <= i_bus_data;
            end
        end
    end

    // The ack also drops at once with data valid, as the dc clear would do.
    assign o_word_taken_ack = ack_ff && i_data_here;
    // Outside a ready test the bus shows the inverse, so stale data never matches.
    assign o_bus_data = o_ready_test_return ? i_in_word : ~i_in_word;
endmodule // io_periph_model
`default_nettype wire

// ### dv/io_xfer_host_tb_top.sv
// Self-checking bench for the host side of the word transfer handshake.
`timescale 1ns/1ps
`default_nettype none
module io_xfer_host_tb_top;
    import io_xfer_pkg::*;
    localparam logic [UNIT_W-1:0] U = 6'h2A;
    logic clk, rstn, cv, ci, cm, brdy, crdy, done, drdy, mw, chn, idx, irqb, xi, isy, wm, dh;
    logic rtr, csr, ack;
    logic [WORD_W-1:0] ins, opd, acc, inw, bd_h, bd_d, outr, accn;
    logic [ADDR_W-1:0] pc, pcn, maddr;
    logic [UNIT_W-1:0] un;
    int n_mismatch = 0;
    int n_tests = 0;
    int cyc = 0;

    io_xfer_host io_xfer_host_inst (.i_clk_sys(clk), .i_resetn(rstn), .i_cmd_valid(cv),
        .o_cmd_ready(crdy), .i_cmd_input(ci), .i_cmd_mem(cm), .i_cmd_instr(ins),
        .i_cmd_operand(opd), .i_cmd_acc(acc), .i_cmd_pc(pc), .o_done(done),
        .o_dev_ready(drdy), .o_pc_next(pcn), .o_acc_next(accn), .o_mem_addr(maddr),
        .o_mem_write(mw), .o_chain(chn), .o_index(idx), .o_irq_block(irqb),
        .o_xfer_instr(xi), .o_instr_sync(isy), .o_wait_mode(wm), .o_unit(un),
        .o_data_here(dh), .o_bus_data(bd_h), .i_ready_test_return(rtr),
        .i_cycle_sync_return(csr), .i_word_taken_ack(ack), .i_bus_data(bd_d));
    io_periph_model #(.MY_UNIT(U)) io_periph_model_inst (.i_clk_sys(clk), .i_resetn(rstn),
        .i_xfer_instr(xi), .i_instr_sync(isy), .i_wait_mode(wm), .i_unit(un),
        .i_data_here(dh), .i_bus_data(bd_h), .i_buf_ready(brdy), .i_in_word(inw),
        .o_ready_test_return(rtr), .o_cycle_sync_return(csr), .o_word_taken_ack(ack),
        .o_out_reg(outr), .o_bus_data(bd_d));

    // Clock and a ceiling well above ten transfers of a few dozen cycles each.
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            n_mismatch++;
            stop_test();
        end
    end

    task automatic chk(input string nm, input logic [WORD_W-1:0] e, input logic [WORD_W-1:0] g);
        n_tests++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            n_mismatch++;
        end
    endtask

    task automatic stop_test;
        $display("Checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // First word: merge, indirect, page, wait flags and our unit number.
    function automatic logic [WORD_W-1:0] mk(input logic m, i, p, w);
        return {4'h0, m, i, p, 2'b00, w, U};
    endfunction

    // One command; the buffer turns ready after dly cycles, never if dly is huge.
    task automatic run(input logic inp, mem, input logic [WORD_W-1:0] iw, ow, input int dly);
        int n;
        chk("idle", 16'h0001, {14'h0000, xi, crdy});
        ci = inp;
        cm = mem;
        ins = iw;
        opd = ow;
        brdy = (dly == 0);
        cv = 1'b1;
        @(posedge clk);
        #5 cv = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 400) begin
            if (n == dly) brdy = 1'b1;
            if (n == dly - 3 && dly > 8) chk("irq_block", 16'h0001, {15'h0000, irqb});
            if (n == dly - 3 && dly > 8) chk("xfer_instr", 16'h0001, {15'h0000, xi});
            @(posedge clk);
            #5 n++;
        end
        if (n >= 400) begin
            n_mismatch++;
            stop_test();
        end
    endtask

    task automatic res(input logic [ADDR_W-1:0] inc, input logic rdy);
        chk("pc_next", {1'b0, pc + inc}, {1'b0, pcn});
        chk("dev_ready", {15'h0000, rdy}, {15'h0000, drdy});
    endtask

    initial begin
        {rstn, cv, ci, cm, brdy} = 5'h00;
        {ins, opd, acc, inw, pc} = {32'h0000_0000, 32'hA55A_3CC3, 15'h4010};
        repeat (20) @(posedge clk);
        #5 rstn = 1'b1;
        run(1'b0, 1'b0, mk(0, 0, 0, 1), 16'h0000, 0);
        chk("out_reg", acc, outr);
        res(15'h0002, 1'b1);
        run(1'b0, 1'b1, mk(0, 0, 0, 0), 16'h1234, 0);
        chk("out_reg", 16'h1234, outr);
        res(15'h0003, 1'b1);
        run(1'b0, 1'b0, mk(0, 0, 0, 0), 16'h0000, 999);
        chk("out_reg", 16'h1234, outr);
        res(15'h0001, 1'b0);
        run(1'b0, 1'b0, mk(0, 0, 0, 1), 16'h0000, 20);
        chk("out_reg", acc, outr);
        run(1'b1, 1'b0, mk(0, 0, 0, 0), 16'h0000, 0);
        chk("acc_next", inw, accn);
        run(1'b1, 1'b0, mk(1, 0, 0, 1), 16'h0000, 0);
        chk("acc_merge", 16'hA5DB, accn);
        res(15'h0002, 1'b1);
        run(1'b1, 1'b1, mk(0, 0, 0, 0), 16'h7ABC, 0);
        chk("mem_addr", 16'h7ABC, {1'b0, maddr});
        chk("mem_write", 16'h0001, {15'h0000, mw});
        run(1'b1, 1'b1, mk(0, 1, 1, 0), 16'hC123, 0);
        chk("mem_addr", 16'h4123, {1'b0, maddr});
        chk("chain_index", 16'h0003, {14'h0000, chn, idx});
        run(1'b1, 1'b1, mk(0, 1, 0, 1), 16'h4FFF, 0);
        chk("mem_addr", 16'h0FFF, {1'b0, maddr});
        chk("chain_index", 16'h0001, {14'h0000, chn, idx});
        res(15'h0003, 1'b1);
        run(1'b1, 1'b1, mk(0, 0, 0, 0), 16'h0100, 999);
        chk("mem_write", 16'h0000, {15'h0000, mw});
        res(15'h0002, 1'b0);
        stop_test();
    end
endmodule // io_xfer_host_tb_top
`default_nettype wire
